// *** src/bfp_ctrl.v ***
// Buck fault protection controller: gate enables, hiccup, fault flags
//
// Behaviour
// - Off period above trip: both switches off
// - Continuous conduction: negative valley limit applied
// - Current limit events latch output current flags
// - Undervoltage held 1 ms: both drivers off
// - Hiccup: wait 8.96 ms plus seven soft-starts
// - Persisting fault repeats hiccup cycling forever
// - Undervoltage protection armed after soft-start
// - Overvoltage latches high off, low on
// - Overvoltage with negative limit: brief high pulse
// - Out-of-bound: high off, no fault, no latch
// - Supply lockout shuts off, resumes on recovery
// - Lockout while enabled latches input flags
// - Overtemperature shuts off, latches temperature flag
// - Eight frequencies, each with ripple constant
// - Clear-faults command clears all flags except those whose event is active in that cycle
`timescale 1ns/10ps
`default_nettype none
`include "bfp_defs.vh"

module bfp_ctrl #(
	parameter UV_DELAY_CYC = `BFP_UV_DELAY_NS / `BFP_CLK_PERIOD_NS,
	parameter HICCUP_BASE_CYC = `BFP_HICCUP_BASE_NS / `BFP_CLK_PERIOD_NS,
	parameter SS_STEP_CYC = `BFP_SS_STEP_NS / `BFP_CLK_PERIOD_NS
) (
	input wire clk, // Clock, 40 MHz
	input wire rst_n, // Asynchronous reset, active low
	input wire ce, // Clock enable, freezes all state when low
	input wire [`BFP_AW-1:0] addr, // Register address
	input wire [`BFP_DW-1:0] wdata, // Register write data
	input wire wr, // Write strobe
	input wire rd, // Read strobe
	output reg [`BFP_DW-1:0] rdata, // Read data, cycle after rd
	output wire irq, // Interrupt, level, active high
	input wire pos_current_limit, // Valley current above positive trip
	input wire neg_current_limit_detect, // Valley current below negative trip
	input wire undervolt_cmp, // Feedback below 68 percent of target
	input wire overvolt_cmp, // Feedback above 120 percent of target
	input wire out_of_bound_cmp, // Feedback above 108 percent of target
	input wire supply_low, // Supply below lockout threshold
	input wire over_temp, // Die above temperature threshold
	input wire en_pin, // Enable pin
	input wire pwm_high_req, // Modulator asks for high-side on
	input wire soft_start_done, // Soft-start ramp complete
	output reg converter_run, // Run request to soft-start and modulator
	output reg hs_en, // High-side gate drive enable
	output reg ls_en, // Low-side gate drive enable
	output reg [2:0] freq_sel, // Selected switching frequency
	output reg [2:0] soft_start_sel, // Soft-start time in ms minus one
	output reg [7:0] ripple_tc // Ripple time constant in us
);

	localparam ST_OFF = 3'h0;
	localparam ST_RUN = 3'h1;
	localparam ST_UV_OFF = 3'h2;
	localparam ST_HICCUP = 3'h3;
	localparam ST_OV_LATCH = 3'h4;

	localparam OV_ON_CYC = (`BFP_OV_ON_NS + `BFP_CLK_PERIOD_NS - 1) / `BFP_CLK_PERIOD_NS;
	localparam SS_MULT_CYC = `BFP_SS_MULT * SS_STEP_CYC;

	// ------------------------------------------------------------------------
	// Input synchronisation
	// ------------------------------------------------------------------------
	wire [`BFP_NSYNC-1:0] raw_in;
	wire [`BFP_NSYNC-1:0] sync_in;

	assign raw_in[`BFP_IN_POS] = pos_current_limit;
	assign raw_in[`BFP_IN_NEG] = neg_current_limit_detect;
	assign raw_in[`BFP_IN_UV] = undervolt_cmp;
	assign raw_in[`BFP_IN_OV] = overvolt_cmp;
	assign raw_in[`BFP_IN_OOB] = out_of_bound_cmp;
	assign raw_in[`BFP_IN_SUPPLY] = supply_low;
	assign raw_in[`BFP_IN_TEMP] = over_temp;
	assign raw_in[`BFP_IN_EN] = en_pin;
	assign raw_in[`BFP_IN_PWM] = pwm_high_req;

	bfp_sync #(
		.W(`BFP_NSYNC)
	) u_sync (
		.clk(clk),
		.rst_n(rst_n),
		.ce(ce),
		.d(raw_in),
		.q(sync_in)
	);

	wire pos_s = sync_in[`BFP_IN_POS];
	wire neg_s = sync_in[`BFP_IN_NEG];
	wire uv_s = sync_in[`BFP_IN_UV];
	wire ov_s = sync_in[`BFP_IN_OV];
	wire oob_s = sync_in[`BFP_IN_OOB];
	wire supply_s = sync_in[`BFP_IN_SUPPLY];
	wire temp_s = sync_in[`BFP_IN_TEMP];
	wire en_s = sync_in[`BFP_IN_EN];
	wire pwm_s = sync_in[`BFP_IN_PWM];

	// ------------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------------
	reg [`BFP_DW-1:0] ctrl;
	reg [`BFP_DW-1:0] status;
	reg [`BFP_DW-1:0] mask;
	reg [2:0] state;
	reg [2:0] next_state;
	reg [`BFP_DW-1:0] next_status;
	reg [`BFP_DW-1:0] events;
	reg next_hs;
	reg next_ls;

	wire on_off = ctrl[`BFP_CTRL_ON_OFF];
	wire hiccup_en = ctrl[`BFP_CTRL_HICCUP];
	wire fccm = ctrl[`BFP_CTRL_FCCM];
	wire enabled = en_s | on_off;
	wire blocked = supply_s | temp_s;
	wire in_run = (state == ST_RUN);
	// Soft-start always runs in discontinuous conduction
	wire continuous_conduction = fccm & in_run & soft_start_done;
	wire uv_armed = in_run & soft_start_done;

	wire wr_ctrl = wr & (addr == `BFP_ADDR_CTRL);
	wire wr_cfg = wr & (addr == `BFP_ADDR_CONFIG);
	wire wr_status = wr & (addr == `BFP_ADDR_STATUS);
	wire wr_mask = wr & (addr == `BFP_ADDR_MASK);
	wire wr_clear = wr & (addr == `BFP_ADDR_CLEAR);

	// ------------------------------------------------------------------------
	// Ripple time constant lookup
	// ------------------------------------------------------------------------
	function [7:0] tc_lookup;
		input [2:0] sel;
		begin
			case (sel)
				3'h0: tc_lookup = `BFP_TC_275;
				3'h1: tc_lookup = `BFP_TC_325;
				3'h2: tc_lookup = `BFP_TC_425;
				3'h3: tc_lookup = `BFP_TC_525;
				3'h4: tc_lookup = `BFP_TC_625;
				3'h5: tc_lookup = `BFP_TC_750;
				3'h6: tc_lookup = `BFP_TC_850;
				default: tc_lookup = `BFP_TC_1000;
			endcase
		end
	endfunction

	// ------------------------------------------------------------------------
	// Timers
	// ------------------------------------------------------------------------
	wire uv_busy;
	wire uv_done;
	wire ov_busy;
	wire ov_done;
	wire uv_expire = uv_done & in_run;
	wire hiccup_expire = uv_done & (state == ST_HICCUP);
	wire [`BFP_TMR_W-1:0] ss_ms = {{(`BFP_TMR_W-4){1'b0}}, {1'b0, soft_start_sel} + 4'h1};
	wire [`BFP_TMR_W-1:0] hiccup_load;
	wire [`BFP_TMR_W-1:0] uv_load;
	wire uv_start;
	wire uv_abort;
	wire ov_start;

	assign hiccup_load = HICCUP_BASE_CYC[`BFP_TMR_W-1:0] + ss_ms * SS_MULT_CYC[`BFP_TMR_W-1:0];
	assign uv_load = uv_expire ? hiccup_load : UV_DELAY_CYC[`BFP_TMR_W-1:0];
	assign uv_start = (uv_armed & uv_s & ~uv_busy & ~uv_done & ~blocked & enabled & ~ov_s)
		| (uv_expire & hiccup_en);
	assign uv_abort = (in_run & (~uv_s | ~uv_armed)) | (state == ST_OFF);
	assign ov_start = (state == ST_OV_LATCH) & neg_s & ~ov_busy & ~hs_en;

	bfp_timer u_uv_timer (
		.clk(clk),
		.rst_n(rst_n),
		.ce(ce),
		.start(uv_start),
		.abort(uv_abort),
		.load(uv_load),
		.busy(uv_busy),
		.done(uv_done)
	);

	bfp_timer u_ov_timer (
		.clk(clk),
		.rst_n(rst_n),
		.ce(ce),
		.start(ov_start),
		.abort(state != ST_OV_LATCH),
		.load(OV_ON_CYC[`BFP_TMR_W-1:0]),
		.busy(ov_busy),
		.done(ov_done)
	);

	// ------------------------------------------------------------------------
	// Protection state machine
	// ------------------------------------------------------------------------
	always @* begin
		next_state = state;
		case (state)
			ST_OFF: begin
				if (enabled & ~blocked) begin
					next_state = ST_RUN;
				end
			end
			ST_RUN: begin
				if (~enabled | blocked) begin
					next_state = ST_OFF;
				end else if (ov_s) begin
					next_state = ST_OV_LATCH;
				end else if (uv_expire) begin
					next_state = hiccup_en ? ST_HICCUP : ST_UV_OFF;
				end
			end
			ST_UV_OFF: begin
				if (~enabled) begin
					next_state = ST_OFF;
				end
			end
			ST_HICCUP: begin
				if (~enabled) begin
					next_state = ST_OFF;
				end else if (hiccup_expire) begin
					next_state = ST_OFF;
				end
			end
			ST_OV_LATCH: begin
				if (~enabled) begin
					next_state = ST_OFF;
				end
			end
			default: begin
				next_state = ST_OFF;
			end
		endcase
	end

	// ------------------------------------------------------------------------
	// Gate drive decisions
	// ------------------------------------------------------------------------
	always @* begin
		next_hs = 1'b0;
		next_ls = 1'b0;
		if (state == ST_OV_LATCH) begin
			if (ov_start | ov_busy) begin
				next_hs = 1'b1;
				next_ls = 1'b0;
			end else begin
				next_ls = 1'b1;
			end
		end else if (in_run & (next_state == ST_RUN)) begin
			if (~hs_en & pos_s) begin
				next_hs = 1'b0;
				next_ls = 1'b0;
			end else if (pwm_s & ~oob_s) begin
				next_hs = 1'b1;
			end else begin
				next_ls = ~(continuous_conduction & neg_s);
			end
			if (oob_s) begin
				next_hs = 1'b0;
			end
		end
		if (blocked) begin
			next_hs = 1'b0;
			next_ls = 1'b0;
		end
	end

	// ------------------------------------------------------------------------
	// Fault events and sticky status
	// ------------------------------------------------------------------------
	always @* begin
		events = {`BFP_DW{1'b0}};
		events[`BFP_ST_POS_OC] = in_run & ~hs_en & pos_s;
		events[`BFP_ST_NEG_OC] = continuous_conduction & ~hs_en & neg_s;
		events[`BFP_ST_OUTPUT_CURRENT_FAULT_FLAG] = events[`BFP_ST_POS_OC] | events[`BFP_ST_NEG_OC];
		events[`BFP_ST_VIN_UV] = supply_s & enabled;
		events[`BFP_ST_INPUT] = supply_s & enabled;
		events[`BFP_ST_TEMP] = temp_s;
		events[`BFP_ST_UV] = uv_expire;
		events[`BFP_ST_OV] = in_run & ov_s & enabled & ~blocked;
		if (wr_clear) begin
			next_status = events;
		end else if (wr_status) begin
			next_status = (status & ~wdata) | events;
		end else begin
			next_status = status | events;
		end
	end

	assign irq = |(status & mask);

	// ------------------------------------------------------------------------
	// Clocked state
	// ------------------------------------------------------------------------
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_OFF;
			hs_en <= 1'b0;
			ls_en <= 1'b0;
			converter_run <= 1'b0;
			ctrl <= `BFP_CTRL_RST;
			status <= `BFP_STATUS_RST;
			mask <= `BFP_MASK_RST;
			freq_sel <= 3'h0;
			soft_start_sel <= 3'h0;
			ripple_tc <= `BFP_TC_275;
		end else if (ce) begin
			state <= next_state;
			hs_en <= next_hs;
			ls_en <= next_ls;
			converter_run <= (next_state == ST_RUN);
			status <= next_status;
			ripple_tc <= tc_lookup(freq_sel);
			if (wr_ctrl) begin
				ctrl <= wdata & `BFP_CTRL_MASK;
			end
			if (wr_mask) begin
				mask <= wdata;
			end
			if (wr_cfg) begin
				freq_sel <= wdata[`BFP_CFG_FREQ_HI:`BFP_CFG_FREQ_LO];
				soft_start_sel <= wdata[`BFP_CFG_SS_HI:`BFP_CFG_SS_LO];
			end
		end
	end

	// ------------------------------------------------------------------------
	// Read port
	// ------------------------------------------------------------------------
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= {`BFP_DW{1'b0}};
		end else if (ce) begin
			if (!rd) begin
				rdata <= {`BFP_DW{1'b0}};
			end else if (addr == `BFP_ADDR_CTRL) begin
				rdata <= ctrl;
			end else if (addr == `BFP_ADDR_CONFIG) begin
				rdata <= {2'h0, soft_start_sel, freq_sel};
			end else if (addr == `BFP_ADDR_STATUS) begin
				rdata <= status;
			end else if (addr == `BFP_ADDR_MASK) begin
				rdata <= mask;
			end else if (addr == `BFP_ADDR_STATE) begin
				rdata <= {hs_en, ls_en, uv_armed, converter_run, uv_busy, state};
			end else if (addr == `BFP_ADDR_RIPPLE) begin
				rdata <= ripple_tc;
			end else begin
				rdata <= {`BFP_DW{1'b0}};
			end
		end
	end

endmodule

`default_nettype wire

// *** shared/bfp_defs.vh ***
// Constants of the buck fault protection controller
`ifndef BFP_DEFS_VH
`define BFP_DEFS_VH

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define BFP_CLK_PERIOD_NS 25
`define BFP_UV_DELAY_NS 1000000
`define BFP_HICCUP_BASE_NS 8960000
`define BFP_SS_STEP_NS 1000000
`define BFP_SS_MULT 7
`define BFP_OV_ON_NS 200
`define BFP_TMR_W 22

// ----------------------------------------------------------------------------
// Register bus
// ----------------------------------------------------------------------------
`define BFP_AW 4
`define BFP_DW 8
`define BFP_ADDR_CTRL 4'h0
`define BFP_ADDR_CONFIG 4'h1
`define BFP_ADDR_STATUS 4'h2
`define BFP_ADDR_MASK 4'h3
`define BFP_ADDR_CLEAR 4'h4
`define BFP_ADDR_STATE 4'h5
`define BFP_ADDR_RIPPLE 4'h6

// Control register fields and reset value
`define BFP_CTRL_ON_OFF 0
`define BFP_CTRL_HICCUP 1
`define BFP_CTRL_FCCM 2
`define BFP_CTRL_RST 8'h02
`define BFP_CTRL_MASK 8'h07

// Config register fields and reset value
`define BFP_CFG_FREQ_LO 0
`define BFP_CFG_FREQ_HI 2
`define BFP_CFG_SS_LO 3
`define BFP_CFG_SS_HI 5
`define BFP_CFG_RST 8'h00
`define BFP_CFG_MASK 8'h3F

// Status flag positions
`define BFP_ST_POS_OC 0
`define BFP_ST_NEG_OC 1
`define BFP_ST_OUTPUT_CURRENT_FAULT_FLAG 2
`define BFP_ST_VIN_UV 3
`define BFP_ST_INPUT 4
`define BFP_ST_TEMP 5
`define BFP_ST_UV 6
`define BFP_ST_OV 7
`define BFP_STATUS_RST 8'h00
`define BFP_MASK_RST 8'h00

// Ripple time constants in microseconds per frequency selection
`define BFP_TC_275 8'h4B
`define BFP_TC_325 8'h4B
`define BFP_TC_425 8'h3E
`define BFP_TC_525 8'h3E
`define BFP_TC_625 8'h28
`define BFP_TC_750 8'h30
`define BFP_TC_850 8'h1A
`define BFP_TC_1000 8'h24

// Input synchroniser bit positions
`define BFP_NSYNC 9
`define BFP_IN_POS 0
`define BFP_IN_NEG 1
`define BFP_IN_UV 2
`define BFP_IN_OV 3
`define BFP_IN_OOB 4
`define BFP_IN_SUPPLY 5
`define BFP_IN_TEMP 6
`define BFP_IN_EN 7
`define BFP_IN_PWM 8

`endif

// *** src/bfp_sync.v ***
// Two-flop synchroniser for a vector of asynchronous inputs
`timescale 1ns/10ps
`default_nettype none

module bfp_sync #(
	parameter W = 1
) (
	input wire clk, // Clock
	input wire rst_n, // Asynchronous reset, active low
	input wire ce, // Clock enable
	input wire [W-1:0] d, // Asynchronous inputs
	output wire [W-1:0] q // Synchronised outputs
);

	genvar i;
	generate
		for (i = 0; i < W; i = i + 1) begin : g_bit
			reg meta;
			reg stable;
			always @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					meta <= 1'b0;
					stable <= 1'b0;
				end else if (ce) begin
					meta <= d[i];
					stable <= meta;
				end
			end
			assign q[i] = stable;
		end
	endgenerate

endmodule

`default_nettype wire

// *** src/bfp_timer.v ***
// One-shot down counter with load, abort and expiry pulse
`timescale 1ns/10ps
`default_nettype none
`include "bfp_defs.vh"

module bfp_timer (
	input wire clk, // Clock
	input wire rst_n, // Asynchronous reset, active low
	input wire ce, // Clock enable
	input wire start, // Load and start counting
	input wire abort, // Stop without expiry
	input wire [`BFP_TMR_W-1:0] load, // Cycles to count
	output reg busy, // Counting
	output reg done // One-cycle expiry pulse
);

	reg [`BFP_TMR_W-1:0] cnt;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= {`BFP_TMR_W{1'b0}};
			busy <= 1'b0;
			done <= 1'b0;
		end else if (ce) begin
			done <= 1'b0;
			if (start) begin
				cnt <= load;
				busy <= 1'b1;
			end else if (abort) begin
				busy <= 1'b0;
			end else if (busy) begin
				if (cnt <= {{(`BFP_TMR_W-1){1'b0}}, 1'b1}) begin
					busy <= 1'b0;
					done <= 1'b1;
				end else begin
					cnt <= cnt - {{(`BFP_TMR_W-1){1'b0}}, 1'b1};
				end
			end
		end
	end

endmodule

`default_nettype wire

// *** verif/bfp_ctrl_assertions.sv ***
// Port-level checks of the protection controller
`timescale 1ns/10ps
`default_nettype none
`include "bfp_defs.vh"

module bfp_ctrl_assertions #(
	parameter UV_DELAY_CYC = 20
) (
	input wire clk, // Clock
	input wire rst_n, // Reset
	input wire rd, // Read strobe
	input wire [`BFP_DW-1:0] rdata, // Read data
	input wire irq, // Interrupt
	input wire pos_current_limit, // Positive trip
	input wire neg_current_limit_detect, // Negative trip
	input wire undervolt_cmp, // Undervoltage
	input wire overvolt_cmp, // Overvoltage
	input wire out_of_bound_cmp, // Out of bound
	input wire supply_low, // Lockout
	input wire over_temp, // Overtemperature
	input wire en_pin, // Enable pin
	input wire soft_start_done, // Ramp done
	input wire converter_run, // Run request
	input wire hs_en, // High side
	input wire ls_en // Low side
);
default clocking @(posedge clk); endclocking
default disable iff (!rst_n);
// ----
// Armed undervoltage cycle count
// ----
reg [15:0] uv_cnt;
always @(posedge clk or negedge rst_n) begin
	if (!rst_n) begin
		uv_cnt <= 16'h0000;
	end else if (undervolt_cmp && soft_start_done) begin
		uv_cnt <= uv_cnt + 16'h0001;
	end else begin
		uv_cnt <= 16'h0000;
	end
end
chk_supply_off: assert property (supply_low [*4] |-> !hs_en && !ls_en)
	else $error("gate on in lockout");
chk_oob_hs: assert property (out_of_bound_cmp [*4] ##0 converter_run |-> !hs_en)
	else $error("high side on out of bound");
chk_cycle_limit: assert property (pos_current_limit [*4] ##0 !hs_en && converter_run
	|=> !hs_en && !ls_en)
	else $error("switch on above trip");
chk_ov_entry: assert property ($rose(overvolt_cmp) && converter_run &&
	!neg_current_limit_detect |-> ##4 !hs_en && ls_en)
	else $error("overvoltage not latched");
chk_ov_hold: assert property ((en_pin && !neg_current_limit_detect && !supply_low && !over_temp) [*4]
	##0 (ls_en && !hs_en && !converter_run) |=> ls_en)
	else $error("low side released in latch");
chk_ov_pulse: assert property ($rose(hs_en) && $past(ls_en) && !converter_run
	|-> (hs_en && !ls_en) [*8])
	else $error("short discharge pulse");
chk_uv_bound: assert property (uv_cnt > UV_DELAY_CYC + 8 |-> !hs_en && !ls_en)
	else $error("no undervoltage shutdown");
chk_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00)
	else $error("read data outside slot");
cover property ($fell(converter_run));
cover property ($rose(hs_en) && $past(ls_en) && !converter_run);
cover property ($rose(irq));
endmodule
`default_nettype wire

// *** verif/bfp_stage_model.sv ***
// Power stage and valley current sensing model
`timescale 1ns/10ps
`default_nettype none

module bfp_stage_model (
	input wire clk, // Clock
	input wire hs_en, // High side
	input wire ls_en, // Low side
	input wire overload, // Load above trip
	input wire reverse, // Reverse current
	output reg pos_lim = 1'h0, // Positive trip
	output reg neg_lim = 1'h0 // Negative trip
);
always @(posedge clk) begin
	pos_lim <= overload && !hs_en;
	neg_lim <= reverse && ls_en;
end
endmodule
`default_nettype wire

// *** verif/tb_bfp_ctrl.sv ***
// Self-checking bench of the protection controller
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin num_checks = num_checks + 1; if ((g) !== (e)) begin miscompares = miscompares + 1; $display("wrong value %0t %h %h", $time, (g), (e)); end end

module tb_bfp_ctrl;
localparam UVD = 20;
localparam HB = 50;
localparam SS = 5;
reg clk = 1'h0, rst_n = 1'h0, wr = 1'h0, rd = 1'h0, pwm = 1'h0, ssd = 1'h0;
reg uv = 1'h0, ov = 1'h0, out_of_bound_protect = 1'h0, sup = 1'h0, tmp = 1'h0, en = 1'h0, olp = 1'h0, oln = 1'h0;
reg [3:0] addr = 4'h0;
reg [7:0] wdata = 8'h00;
reg [15:0] seed = 16'h4726;
reg [5:0] sc = 6'h00;
reg [2:0] ss = 3'h0;
integer miscompares = 0, num_checks = 0, n, i;
wire [7:0] rdata, rtc;
wire [2:0] fs, sss;
wire irq, run, hs, ls, pcl, neg_current_limit;
bfp_ctrl #(.UV_DELAY_CYC(UVD), .HICCUP_BASE_CYC(HB), .SS_STEP_CYC(SS)) DUT (
	.clk(clk), .rst_n(rst_n), .ce(1'h1), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
	.rdata(rdata), .irq(irq), .pos_current_limit(pcl), .neg_current_limit_detect(neg_current_limit),
	.undervolt_cmp(uv), .overvolt_cmp(ov), .out_of_bound_cmp(out_of_bound_protect), .supply_low(sup),
	.over_temp(tmp), .en_pin(en), .pwm_high_req(pwm), .soft_start_done(ssd),
	.converter_run(run), .hs_en(hs), .ls_en(ls), .freq_sel(fs), .soft_start_sel(sss),
	.ripple_tc(rtc));
bfp_stage_model u_stage (.clk(clk), .hs_en(hs), .ls_en(ls), .overload(olp), .reverse(oln),
	.pos_lim(pcl), .neg_lim(neg_current_limit));
function [15:0] xs(input [15:0] s);
	reg [15:0] t;
	begin
		t = s ^ (s << 7);
		t = t ^ (t >> 9);
		xs = t ^ (t << 8);
	end
endfunction
function [7:0] tcx(input [2:0] f);
	begin
		case (f)
		3'h0, 3'h1: tcx = 8'h4B;
		3'h2, 3'h3: tcx = 8'h3E;
		3'h4: tcx = 8'h28;
		3'h5: tcx = 8'h30;
		3'h6: tcx = 8'h1A;
		default: tcx = 8'h24;
		endcase
	end
endfunction
function integer hic(input [2:0] s);
	hic = HB + 7 * SS * (s + 1);
endfunction
task print_verdict;
	begin
		if (miscompares == 0 && num_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	end
endtask
task cyc(input integer k);
	repeat (k) @(posedge clk);
endtask
task wreg(input [3:0] a, input [7:0] d);
	begin
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'h1;
		@(posedge clk);
		wr <= 1'h0;
	end
endtask
task chkreg(input [3:0] a, input [7:0] e);
	begin
		@(posedge clk);
		addr <= a;
		rd <= 1'h1;
		@(posedge clk);
		rd <= 1'h0;
		@(posedge clk);
		`CHK(rdata, e)
	end
endtask
task wait_run(input v);
	begin
		n = 0;
		while (run !== v && n < 800) begin
			@(posedge clk);
			n = n + 1;
		end
		if (run !== v) begin
			miscompares = miscompares + 1;
			print_verdict;
		end
	end
endtask
always #12.5 clk = ~clk;
// Random modulator demand; ramp reported done 64 cycles into a run
always @(posedge clk) begin
	seed <= xs(seed);
	pwm <= seed[0];
	sc <= run ? sc + {5'h00, sc != 6'h3F} : 6'h00;
	ssd <= sc == 6'h3F;
end
initial begin
	cyc(6);
	rst_n <= 1'h1;
	chkreg(4'h0, 8'h02);
	chkreg(4'h2, 8'h00);
	chkreg(4'h3, 8'h00);
	chkreg(4'hF, 8'h00);
	wreg(4'h6, 8'hFF);
	chkreg(4'h6, 8'h4B);
	for (i = 0; i < 8; i = i + 1) begin
		ss = seed[5:3];
		wreg(4'h1, {2'h0, ss, i[2:0]});
		cyc(2);
		`CHK({sss, fs, rtc}, {ss, i[2:0], tcx(i[2:0])})
	end
	wreg(4'h0, 8'h07);
	wait_run(1'h1);
	cyc(80);
	olp <= 1'h1;
	wreg(4'h3, 8'h01);
	cyc(20);
	olp <= 1'h0;
	`CHK(irq, 1'h1)
	wreg(4'h3, 8'h00);
	cyc(5);
	`CHK(irq, 1'h0)
	chkreg(4'h2, 8'h05);
	wreg(4'h2, 8'h05);
	chkreg(4'h2, 8'h00);
	oln <= 1'h1;
	cyc(20);
	oln <= 1'h0;
	cyc(5);
	chkreg(4'h2, 8'h06);
	wreg(4'h4, 8'h00);
	chkreg(4'h2, 8'h00);
	for (i = 0; i < 2; i = i + 1) begin
		uv <= 1'h1;
		cyc(UVD - 5);
		uv <= 1'h0;
		cyc(3);
	end
	`CHK(run, 1'h1)
	uv <= 1'h1;
	wait_run(1'h0);
	`CHK(n >= UVD && n <= UVD + 8, 1'h1)
	`CHK({hs, ls}, 2'h0)
	wait_run(1'h1);
	`CHK(n >= hic(ss) && n <= hic(ss) + 5, 1'h1)
	wait_run(1'h0);
	`CHK(n >= UVD + 63, 1'h1)
	uv <= 1'h0;
	chkreg(4'h2, 8'h40);
	wait_run(1'h1);
	wreg(4'h0, 8'h05);
	wreg(4'h4, 8'h00);
	cyc(80);
	uv <= 1'h1;
	wait_run(1'h0);
	uv <= 1'h0;
	cyc(400);
	`CHK(run, 1'h0)
	wreg(4'h0, 8'h04);
	en <= 1'h1;
	wait_run(1'h1);
	wreg(4'h4, 8'h00);
	cyc(80);
	out_of_bound_protect <= 1'h1;
	cyc(8);
	`CHK({run, hs}, 2'h2)
	out_of_bound_protect <= 1'h0;
	chkreg(4'h2, 8'h00);
	for (i = 0; i < 2; i = i + 1) begin
		{tmp, sup} <= 2'h1 << i;
		wait_run(1'h0);
		{tmp, sup} <= 2'h0;
		wait_run(1'h1);
		// Resume is two sync stages plus one state edge, no latching
		`CHK({run, n <= 4}, 2'h3)
		chkreg(4'h2, i ? 8'h20 : 8'h18);
		wreg(4'h4, 8'h00);
	end
	ov <= 1'h1;
	cyc(5);
	`CHK({hs, ls}, 2'h1)
	oln <= 1'h1;
	n = 0;
	repeat (40) begin
		@(posedge clk);
		n = n + (hs === 1'h1);
	end
	`CHK(n >= 8, 1'h1)
	{oln, ov} <= 2'h0;
	// A discharge pulse may start up to three cycles later and runs nine
	cyc(16);
	`CHK({hs, ls}, 2'h1)
	chkreg(4'h2, 8'h80);
	en <= 1'h0;
	cyc(6);
	`CHK({hs, ls}, 2'h0)
	print_verdict;
end
endmodule
bind bfp_ctrl bfp_ctrl_assertions #(.UV_DELAY_CYC(UV_DELAY_CYC)) u_chk (.clk(clk),
	.rst_n(rst_n), .rd(rd), .rdata(rdata), .irq(irq), .pos_current_limit(pos_current_limit),
	.neg_current_limit_detect(neg_current_limit_detect), .undervolt_cmp(undervolt_cmp),
	.overvolt_cmp(overvolt_cmp), .out_of_bound_cmp(out_of_bound_cmp),
	.supply_low(supply_low), .over_temp(over_temp), .en_pin(en_pin),
	.soft_start_done(soft_start_done),
	.converter_run(converter_run), .hs_en(hs_en), .ls_en(ls_en));
`default_nettype wire
